// >>> ocsd_top.sv
// Purpose: Octal latched sink driver, eight open-drain sinks.
// Assumes: Capture clock and clear pins sampled on core_clk_i.
// Notes:   Sink pins need external pull-ups; enable high pulls low.
//          A capture reaches the pins one edge after it is taken.
//          Clear releases every sink at the edge that samples it.
//          Capture clock held high through reset counts as a rise.
`timescale 1ns/10ps

module ocsd_top (
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          clear_n_i,
  input  wire logic                          capture_clk_i,
  input  wire logic [ocsd_pkg::CHANNELS-1:0] capture_input_i,
  output logic      [ocsd_pkg::CHANNELS-1:0] sink_output_n_o,
  output logic      [ocsd_pkg::CHANNELS-1:0] sink_output_oe_o
);

  // Capture clock step between the last sample and this one
  typedef enum logic [1:0] {
    CKEV_LOW,
    CKEV_RISE,
    CKEV_HIGH,
    CKEV_FALL
  } ocsd_ckev_t;

  // Action the channel bank takes at this edge
  typedef enum logic [1:0] {
    ACT_HOLD,
    ACT_LOAD,
    ACT_CLEAR
  } ocsd_act_t;

  // Capture clock tracking
  logic                          cap_clk_prev_r;
  ocsd_ckev_t                    cap_step;

  // Clear and bank control
  logic                          clear_act;
  ocsd_act_t                     bank_act;

  // Sink stage flop outputs, one bit per channel
  logic [ocsd_pkg::CHANNELS-1:0] sink_oe;
  logic [ocsd_pkg::CHANNELS-1:0] sink_lvl;

  // Strobes, data and stored bits to the channel bank
  ocsd_store_if st ();

  genvar ch;

  // Previous capture clock level for edge detection
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_clk_prev_r <= ocsd_pkg::CAP_CLK_IDLE;
    end else begin
      cap_clk_prev_r <= capture_clk_i;
    end
  end

  // Clear pin is active low and sampled like any other pin
  assign clear_act = ~clear_n_i;

  // Classify the capture clock step from last sample to this one
  always_comb begin
    case ({cap_clk_prev_r, capture_clk_i})
      2'h1: begin
        cap_step = CKEV_RISE;
      end
      2'h3: begin
        cap_step = CKEV_HIGH;
      end
      2'h2: begin
        cap_step = CKEV_FALL;
      end
      default: begin
        cap_step = CKEV_LOW;
      end
    endcase
  end

  // Clear outranks every step; only a rise loads, the rest hold
  always_comb begin
    bank_act = ACT_HOLD;
    if (clear_act) begin
      bank_act = ACT_CLEAR;
    end else begin
      case (cap_step)
        CKEV_RISE: begin
          bank_act = ACT_LOAD;
        end
        CKEV_HIGH: begin
          bank_act = ACT_HOLD;
        end
        CKEV_FALL: begin
          bank_act = ACT_HOLD;
        end
        default: begin
          bank_act = ACT_HOLD;
        end
      endcase
    end
  end

  // Strobes and data into the channel bank
  assign st.capture = (bank_act == ACT_LOAD);
  assign st.clear   = (bank_act == ACT_CLEAR);
  assign st.data    = capture_input_i;

  ocsd_channel_bank u_bank (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .st         (st)
  );

  // One sink stage per channel
  generate
    for (ch = 0; ch < ocsd_pkg::CHANNELS; ch++) begin : g_sink
      logic oe_bit_r;
      logic lvl_bit_r;

      // Enable follows the stored bit; clear releases at once
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          oe_bit_r <= ocsd_pkg::SINK_OFF[ch];
        end else if (bank_act == ACT_CLEAR) begin
          oe_bit_r <= ocsd_pkg::SINK_OFF[ch];
        end else begin
          oe_bit_r <= st.stored[ch];
        end
      end

      // Driven level never changes; only the enable does
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          lvl_bit_r <= ocsd_pkg::SINK_LEVEL[ch];
        end else begin
          lvl_bit_r <= ocsd_pkg::SINK_LEVEL[ch];
        end
      end

      assign sink_oe[ch]  = oe_bit_r;
      assign sink_lvl[ch] = lvl_bit_r;
    end
  endgenerate

  // Pins come straight from the per-channel flops
  assign sink_output_oe_o = sink_oe;
  assign sink_output_n_o  = sink_lvl;

endmodule // ocsd_top

// >>> ocsd_pkg.sv
// Purpose: Shared constants for the octal latched sink driver.
// Assumes: Pins arrive synchronous to core_clk_i.
// Notes:   Stored high means the matching sink pulls low.
//
// Contract
// - Eight channels, own flop, shared clock, clear
// - Clear low zeroes store, releases all sinks
// - Capture rising edge stores data; high sinks
// - Clock low or falling edge holds outputs
package ocsd_pkg;

  // Channel count
  localparam int unsigned CHANNELS = 8;

  // Stored bits after reset or clear
  localparam logic [CHANNELS-1:0] STORE_CLEAR = 8'h00;

  // Sink enables after reset or clear: all released
  localparam logic [CHANNELS-1:0] SINK_OFF = 8'h00;

  // Level driven onto a sink pin while enabled
  localparam logic [CHANNELS-1:0] SINK_LEVEL = 8'h00;

  // Idle level of the sampled capture clock
  localparam logic CAP_CLK_IDLE = 1'b0;

endpackage : ocsd_pkg

// >>> ocsd_store_if.sv
// Purpose: Carries capture strobe, clear, data and stored bits.
// Assumes: One clock domain, core_clk_i.
// Notes:   Driver side issues strobes, bank side holds the bits.
`timescale 1ns/10ps

interface ocsd_store_if;
  logic                            capture;
  logic                            clear;
  logic [ocsd_pkg::CHANNELS-1:0]   data;
  logic [ocsd_pkg::CHANNELS-1:0]   stored;

  // Control side
  modport ctrl (output capture, output clear, output data, input stored);
  // Storage side
  modport bank (input capture, input clear, input data, output stored);
endinterface // ocsd_store_if

// >>> ocsd_channel_bank.sv
// Purpose: One storage flip-flop per channel.
// Assumes: Clear and capture are one-cycle qualified levels.
// Notes:   Clear takes priority over capture.
`timescale 1ns/10ps

module ocsd_channel_bank (
  input  wire logic   core_clk_i,
  input  wire logic   rst_n_i,
  ocsd_store_if.bank  st
);

  genvar ch;

  // Independent flop per channel
  generate
    for (ch = 0; ch < ocsd_pkg::CHANNELS; ch++) begin : g_chan
      logic bit_r;

      // Clear wins, else load on capture, else hold
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          bit_r <= ocsd_pkg::STORE_CLEAR[ch];
        end else if (st.clear) begin
          bit_r <= ocsd_pkg::STORE_CLEAR[ch];
        end else if (st.capture) begin
          bit_r <= st.data[ch];
        end
      end

      assign st.stored[ch] = bit_r;
    end
  endgenerate

endmodule // ocsd_channel_bank

// >>> ocsd_chk_sva.sv
// Purpose: Sink driver checks
// Assumes: One clock
// Notes: Bound to ocsd_top
`timescale 1ns/10ps
module ocsd_chk (input logic core_clk_i, input logic rst_n_i, input logic clear_n_i, input logic capture_clk_i,
  input logic [7:0] capture_input_i, input logic [7:0] sink_output_n_o, input logic [7:0] sink_output_oe_o);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire c = clear_n_i, k = capture_clk_i;
  wire [7:0] y = sink_output_oe_o;
  logic armed_r;
  // Skip the first edge after reset, where a held-high clock counts as a rise
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) armed_r <= 1'b0;
    else armed_r <= 1'b1;
  end
  // Pin level, clear, capture, hold
  pin_low_a: assert property (sink_output_n_o == 8'h00) else $error("pin high");
  clr_off_a: assert property (!c |=> y == 8'h00) else $error("no clear");
  cap_store_a: assert property ($rose(k) && c ##1 c |=> y == $past(capture_input_i, 2)) else $error("store");
  low_hold_a: assert property (!k && c ##1 c |=> $stable(y)) else $error("low hold");
  high_hold_a: assert property (armed_r && k && $stable(k) && c ##1 c |=> $stable(y)) else $error("high hold");
  cover property ($rose(k) && c);
  cover property ($rose(k) && !c);
  cover property (k [*3]);
endmodule // ocsd_chk
bind ocsd_top ocsd_chk ocsd_chk_inst (.*);

// >>> ocsd_host.sv
// Purpose: Host model
// Assumes: Acts 1 ns after edge
// Notes: Clock pin idles low
`timescale 1ns/10ps
module ocsd_host (input logic core_clk_i, output logic clear_n_o = 1'b1,
  output logic cap_clk_o = 1'b0, output logic [7:0] data_o = 8'h00);
  // Set the three host pins
  task automatic drive(input logic cn, input logic ck, input logic [7:0] dv);
    @(posedge core_clk_i) #1;
    clear_n_o = cn;
    cap_clk_o = ck;
    data_o = dv;
  endtask
endmodule // ocsd_host

// >>> ocsd_top_tb.sv
// Purpose: Bench
// Assumes: 50 MHz clock
// Notes: Queued notes
`timescale 1ns/10ps
module ocsd_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, c, k;
  logic [7:0] d, oe, lvl, v, x, q[$];
  wire [7:0] pin = lvl | ~oe; // Pull-up wins while a sink is released
  int bad_count = 0, checks_done = 0, seed = 73;
  event ev;
  always #10 clk = ~clk;
  ocsd_host ocsd_host_inst (.core_clk_i(clk), .clear_n_o(c), .cap_clk_o(k), .data_o(d));
  ocsd_top ocsd_top_inst (.core_clk_i(clk), .rst_n_i(rst_n), .clear_n_i(c), .capture_clk_i(k),
    .capture_input_i(d), .sink_output_n_o(lvl), .sink_output_oe_o(oe));
  // Note a value, wait out the two edges
  task automatic note(input logic [7:0] e);
    q.push_back(e);
    repeat (2) @(posedge clk);
    #2 ->ev;
  endtask
  task automatic cmp(input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    bad_count += int'(s !== e);
    if (s !== e) $display("BAD oe exp %h got %h", e, s);
  endtask
  task automatic cmp_pin(input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    bad_count += int'(s !== e);
    if (s !== e) $display("BAD pin exp %h got %h", e, s);
  endtask
  // Oldest note against enables and pin levels
  always @(ev) begin
    x = q.pop_front();
    cmp(x, oe);
    cmp_pin(~x, pin);
  end
  task automatic test_done();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000 bad_count++;
    test_done();
  end
  // Stimulus
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    note(8'h00);
    $display("test reset done");
    repeat (6) begin
      v = 8'($random(seed));
      ocsd_host_inst.drive(1'b1, 1'b0, v);
      ocsd_host_inst.drive(1'b1, 1'b1, v);
      note(v);
      repeat (3) ocsd_host_inst.drive(1'b1, 1'b1, 8'($random(seed)));
      note(v);
      repeat (3) ocsd_host_inst.drive(1'b1, 1'b0, 8'($random(seed)));
      note(v);
    end
    $display("test capture hold done");
    ocsd_host_inst.drive(1'b0, 1'b1, 8'hff);
    note(8'h00);
    ocsd_host_inst.drive(1'b1, 1'b1, 8'($random(seed)));
    note(8'h00);
    $display("test clear done");
    v = 8'($random(seed));
    ocsd_host_inst.drive(1'b1, 1'b0, v);
    ocsd_host_inst.drive(1'b1, 1'b1, v);
    note(v);
    $display("test capture after clear done");
    test_done();
  end
endmodule // ocsd_top_tb
